// [biphase_audio_modulator.sv]
// Our own choices: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/10ps
module biphase_audio_modulator
    import biphase_pkg::*;
(
    // system
    input  wire logic        ref_clk,
    input  wire logic        reset,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic        hready,
    input  wire logic [31:0] hwdata,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // audio source pins
    input  wire logic        tx_master_clk_in,
    input  wire logic        tx_bit_clk_in,
    input  wire logic        tx_frame_clk_in,
    input  wire logic        tx_serial_data_in,
    input  wire logic        aux_serial_audio_in,
    input  wire logic        aux_in5_validity,
    input  wire logic        aux_in6_user,
    // start-up strap
    input  wire logic        int_strap_pin,
    // encoded and shared outputs
    output logic             encoded_stream_out,
    output logic             input_passthrough_out,
    output logic             clkstate_blocksync_out,
    output logic             clkstate_blocksync_oe
);

    // ****************************************************
    // pin synchronisers
    // ****************************************************
    logic [7:0] pins;
    logic [7:0] sy1_q;
    logic [7:0] sy2_q;
    logic [7:0] sy3_q;

    assign pins = {int_strap_pin, aux_in6_user, aux_in5_validity,
                   aux_serial_audio_in, tx_serial_data_in,
                   tx_frame_clk_in, tx_bit_clk_in, tx_master_clk_in};

    // two stages, then a history stage for edges
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            sy1_q <= 8'h00;
            sy2_q <= 8'h00;
            sy3_q <= 8'h00;
        end else begin
            sy1_q <= pins;
            sy2_q <= sy1_q;
            sy3_q <= sy2_q;
        end
    end

    // ****************************************************
    // control registers
    // ****************************************************
    ctrl_t       ctrl_q;
    logic [47:0] cs_q;
    logic [1:0]  vsw_q;
    logic [1:0]  usw_q;
    logic        wr_q;
    logic [7:0]  wa_q;
    logic [31:0] rdata_q;
    logic        ready_q;
    logic        resp_q;

    // ****************************************************
    // strap capture
    // ****************************************************
    logic [1:0] strap_cnt_q;
    logic       mod_en_q;

    // wait until the synchroniser holds the strap level
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            strap_cnt_q <= 2'h0;
            mod_en_q    <= 1'b0;
        end else if (strap_cnt_q != STRAP_WAIT) begin
            strap_cnt_q <= strap_cnt_q + 2'h1;
            if (strap_cnt_q == STRAP_WAIT - 2'h1) begin
                mod_en_q <= ~sy2_q[SY_STRAP];
            end
        end
    end

    // ****************************************************
    // serial input capture
    // ****************************************************
    logic        mclk_rise;
    logic        bclk_rise;
    logic        bclk_fall;
    logic        lr;
    logic        din;
    logic        slot_end;
    logic        left_lvl;
    logic        was_left;
    logic        frame_start;
    logic [23:0] word;
    logic [31:0] sh_q;
    logic        lr_q;

    // edges seen on the synchronised link clocks
    assign mclk_rise = sy2_q[SY_MCLK] & ~sy3_q[SY_MCLK];
    assign bclk_rise = sy2_q[SY_BCLK] & ~sy3_q[SY_BCLK];
    assign bclk_fall = ~sy2_q[SY_BCLK] & sy3_q[SY_BCLK];
    assign lr        = sy2_q[SY_LRCK];
    // serial source, both inputs share the bit and frame clocks
    assign din = ctrl_q.tx_source_sel ? sy2_q[SY_AUX]
                                      : sy2_q[SY_DATA];
    // slot boundary found at a bit clock rise
    assign slot_end    = bclk_rise && (lr != lr_q);
    assign left_lvl    = ctrl_q.tx_frame_polarity ^
                         (ctrl_q.tx_input_format_sel != FMT_I2S);
    assign was_left    = (lr_q == left_lvl);
    assign frame_start = slot_end && !was_left;
    // i2s msb one bit late, else lsb at slot end
    assign word = (ctrl_q.tx_input_format_sel == FMT_I2S)
                  ? sh_q[30:7] : sh_q[23:0];

    // shift serial bits on each bit clock rise
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            sh_q <= 32'h0000_0000;
            lr_q <= 1'b0;
        end else if (bclk_rise) begin
            sh_q <= {sh_q[30:0], din};
            lr_q <= lr;
        end
    end

    // ****************************************************
    // sample and flag latches
    // ****************************************************
    logic        mono;
    logic        take_m;
    logic [23:0] left_q;
    logic [23:0] right_d;
    logic [23:0] right_q;
    logic [23:0] mq0_d;
    logic [23:0] mq0_q;
    logic [23:0] mq1_d;
    logic [23:0] mq1_q;
    logic [1:0]  vp_d;
    logic [1:0]  vp_q;
    logic [1:0]  up_d;
    logic [1:0]  up_q;

    assign mono    = (ctrl_q.mono_mode_sel != MONO_STEREO);
    assign right_d = (slot_end && !was_left) ? word : right_q;
    // mono keeps the last two samples of one channel
    assign take_m = slot_end && mono &&
                    ((ctrl_q.mono_mode_sel == MONO_RIGHT) ^ was_left);
    assign mq0_d  = take_m ? word : mq0_q;
    assign mq1_d  = take_m ? mq0_q : mq1_q;
    // pin flags per slot, index 0 left, 1 right
    assign vp_d = !slot_end ? vp_q : was_left
                  ? {vp_q[1], sy2_q[SY_VAL]}
                  : {sy2_q[SY_VAL], vp_q[0]};
    assign up_d = !slot_end ? up_q : was_left
                  ? {up_q[1], sy2_q[SY_USR]}
                  : {sy2_q[SY_USR], up_q[0]};

    // latch samples and flags
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            left_q  <= 24'h00_0000;
            right_q <= 24'h00_0000;
            mq0_q   <= 24'h00_0000;
            mq1_q   <= 24'h00_0000;
            vp_q    <= 2'h0;
            up_q    <= 2'h0;
        end else begin
            if (slot_end && was_left) begin
                left_q <= word;
            end
            right_q <= right_d;
            mq0_q   <= mq0_d;
            mq1_q   <= mq1_d;
            vp_q    <= vp_d;
            up_q    <= up_d;
        end
    end

    // ****************************************************
    // frame assembly
    // ****************************************************
    function automatic logic [27:0] subframe(
        input logic [23:0] s,
        input logic        v,
        input logic        u,
        input logic        c
    );
        logic [26:0] b;
        b = {c, u, v, s};
        return {^b, b}; // even parity slot
    endfunction

    logic        gate;
    logic        tick;
    logic        run_q;
    logic [6:0]  hc_q;
    logic [7:0]  fr_q;
    logic [7:0]  fr_n;
    logic        start_ev;
    logic        load;
    logic [23:0] sa;
    logic [23:0] sb;
    logic        va;
    logic        vb;
    logic        ua;
    logic        ub;
    logic        cbit;
    logic [27:0] a_q;
    logic [27:0] b_q;

    assign gate = mod_en_q && ctrl_q.modulator_run_ctl;
    // half-cell rate halves in mono
    assign tick = mono ? bclk_rise : (bclk_rise | bclk_fall);
    assign start_ev = !run_q && gate && frame_start;
    assign load = start_ev || (run_q && tick && hc_q == HC_LAST);
    // block index counts output frames
    assign fr_n = (!run_q || fr_q == FR_LAST)
                  ? 8'h00 : fr_q + 8'h01;
    assign sa = mono ? mq1_d : left_q;
    assign sb = mono ? mq0_d : right_d;
    // pin flag when its pin select is set, else software flag
    assign va = ctrl_q.validity_pin_sel ? vp_d[0] : vsw_q[0];
    assign vb = ctrl_q.validity_pin_sel
                ? (mono ? vp_d[0] : vp_d[1])
                : (mono ? vsw_q[0] : vsw_q[1]);
    assign ua = ctrl_q.user_pin_sel ? up_d[0] : usw_q[0];
    assign ub = ctrl_q.user_pin_sel
                ? (mono ? up_d[0] : up_d[1])
                : (mono ? usw_q[0] : usw_q[1]);
    // status bits past 48 go out as zero
    assign cbit = (fr_n < CS_BITS) ? cs_q[fr_n[5:0]] : 1'b0;

    // frame sequencing and subframe loading
    always_ff @(posedge ref_clk) begin
        if (reset || !gate) begin
            run_q <= 1'b0;
            hc_q  <= 7'h00;
            fr_q  <= 8'h00;
            a_q   <= 28'h000_0000;
            b_q   <= 28'h000_0000;
        end else begin
            if (start_ev) begin
                run_q <= 1'b1;
                hc_q  <= 7'h00;
            end else if (run_q && tick) begin
                hc_q <= hc_q + 7'h01;
            end
            if (load) begin
                fr_q <= fr_n;
                a_q  <= subframe(sa, va, ua, cbit);
                b_q  <= subframe(sb, vb, ub, cbit);
            end
        end
    end

    // ****************************************************
    // bi-phase mark encoder
    // ****************************************************
    logic [4:0]  slot;
    logic [4:0]  bidx;
    logic [2:0]  pidx;
    logic [27:0] cur;
    logic [7:0]  pre;
    logic        pre_ref;
    logic        pre_lvl;
    logic        bm_lvl;
    logic        level_q;
    logic        start_q;
    logic        enc_q;
    logic        pass_q;
    logic        bs_q;
    logic        bs_oe_q;

    assign slot = hc_q[5:1];
    assign bidx = slot - SLOT_PRE;
    assign pidx = 3'h7 - {slot[1:0], hc_q[0]};
    assign cur  = hc_q[6] ? b_q : a_q;
    // block, left or right preamble
    assign pre  = hc_q[6] ? PRE_W
                : (fr_q == 8'h00 ? PRE_B : PRE_M);
    assign pre_ref = (hc_q[5:0] == 6'h00) ? level_q : start_q;
    assign pre_lvl = pre[pidx] ^ pre_ref;
    // cell edge always, mid-cell edge for a one
    assign bm_lvl = hc_q[0] ? (level_q ^ cur[bidx])
                            : ~level_q;

    // line level, one half-cell per tick
    always_ff @(posedge ref_clk) begin
        if (reset || !run_q) begin
            level_q <= 1'b0;
            start_q <= 1'b0;
        end else if (tick) begin
            level_q <= (slot < SLOT_PRE) ? pre_lvl : bm_lvl;
            if (hc_q[5:0] == 6'h00) begin
                start_q <= level_q;
            end
        end
    end

    // gated outputs and shared block-sync pin
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            enc_q   <= 1'b0;
            pass_q  <= 1'b0;
            bs_q    <= 1'b0;
            bs_oe_q <= 1'b0;
        end else begin
            enc_q   <= run_q && gate && !ctrl_q.tx_mute_ctl
                       && level_q;
            pass_q  <= run_q && gate && !ctrl_q.tx_mute_ctl
                       && level_q && ctrl_q.tx_source_sel;
            bs_q    <= run_q && gate && fr_q == 8'h00;
            bs_oe_q <= ctrl_q.block_sync_out_sel
                       == BSYNC_TX;
        end
    end

    // ****************************************************
    // master clock ratio monitor
    // ****************************************************
    logic [8:0] mc_cnt_q;
    logic [8:0] mc_last_q;
    logic       ratio_ok;

    // source must keep master clock locked to bit clock
    assign ratio_ok = mc_last_q == ((ctrl_q.tx_mclk_ratio_sel
                      == RATIO_128) ? MCLK_128 : MCLK_256);

    // master clock rises per frame
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            mc_cnt_q  <= 9'h000;
            mc_last_q <= 9'h000;
        end else if (frame_start) begin
            mc_last_q <= mc_cnt_q;
            mc_cnt_q  <= {8'h00, mclk_rise};
        end else if (mclk_rise && mc_cnt_q != 9'h1FF) begin
            mc_cnt_q <= mc_cnt_q + 9'h001;
        end
    end

    // ****************************************************
    // ahb-lite slave
    // ****************************************************
    logic        ap;
    logic        hi_ok;
    logic        w_ok;
    logic [31:0] rmux;
    logic [31:0] status;

    assign ap     = hsel && htrans[1] && hready;
    assign hi_ok  = (haddr[31:8] == 24'h00_0000);
    assign status = {7'h00, mc_last_q, fr_q, 5'h00,
                     ratio_ok, mod_en_q, run_q};
    // read decode, unmapped reads zero
    assign rmux = !hi_ok ? 32'h0000_0000
        : haddr[7:0] == ADDR_CTRL   ? {19'h0_0000, ctrl_q}
        : haddr[7:0] == ADDR_CS_LO  ? cs_q[31:0]
        : haddr[7:0] == ADDR_CS_HI  ? {16'h0000, cs_q[47:32]}
        : haddr[7:0] == ADDR_VALID  ? {30'h0000_0000, vsw_q}
        : haddr[7:0] == ADDR_USER   ? {30'h0000_0000, usw_q}
        : haddr[7:0] == ADDR_STATUS ? status
        : 32'h0000_0000;
    assign w_ok = wr_q;

    // address phase capture, zero wait states
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            wr_q    <= 1'b0;
            wa_q    <= 8'h00;
            rdata_q <= 32'h0000_0000;
            ready_q <= 1'b1;
            resp_q  <= 1'b0;
        end else begin
            wr_q    <= ap && hwrite && hi_ok;
            wa_q    <= haddr[7:0];
            rdata_q <= (ap && !hwrite) ? rmux : 32'h0000_0000;
        end
    end

    // data phase writes
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            ctrl_q <= CTRL_RESET;
            cs_q   <= 48'h0000_0000_0000;
            vsw_q  <= 2'h0;
            usw_q  <= 2'h0;
        end else if (w_ok) begin
            case (wa_q)
                ADDR_CTRL:  ctrl_q <= ctrl_t'(hwdata[CTRL_W-1:0]);
                ADDR_CS_LO: cs_q[31:0] <= hwdata;
                ADDR_CS_HI: cs_q[47:32] <= hwdata[15:0];
                ADDR_VALID: begin
                    if (ctrl_q.validity_write_mode) begin
                        vsw_q <= hwdata[1:0];
                    end
                end
                ADDR_USER:  usw_q <= hwdata[1:0];
                default:    ;
            endcase
        end
    end

    // ****************************************************
    // output drive
    // ****************************************************
    assign hrdata                 = rdata_q;
    assign hreadyout              = ready_q;
    assign hresp                  = resp_q;
    assign encoded_stream_out     = enc_q;
    assign input_passthrough_out  = pass_q;
    assign clkstate_blocksync_out = bs_q;
    assign clkstate_blocksync_oe  = bs_oe_q;

endmodule

// [biphase_pkg.sv]
package biphase_pkg;

    // ****************************************************
    // register map (byte addresses)
    // ****************************************************
    localparam logic [7:0] ADDR_CTRL   = 8'h00;
    localparam logic [7:0] ADDR_CS_LO  = 8'h04;
    localparam logic [7:0] ADDR_CS_HI  = 8'h08;
    localparam logic [7:0] ADDR_VALID  = 8'h0C;
    localparam logic [7:0] ADDR_USER   = 8'h10;
    localparam logic [7:0] ADDR_STATUS = 8'h14;

    // control word, bit 0 is modulator_run_ctl
    typedef struct packed {
        logic [1:0] mono_mode_sel;       // 12:11
        logic       tx_source_sel;       // 10
        logic [1:0] block_sync_out_sel;  // 9:8
        logic       user_pin_sel;        // 7
        logic       validity_write_mode; // 6
        logic       validity_pin_sel;    // 5
        logic       tx_input_format_sel; // 4
        logic       tx_frame_polarity;   // 3
        logic       tx_mclk_ratio_sel;   // 2
        logic       tx_mute_ctl;         // 1
        logic       modulator_run_ctl;   // 0
    } ctrl_t;

    localparam int    CTRL_W     = 13;
    localparam ctrl_t CTRL_RESET = '0;

    // ****************************************************
    // encodings
    // ****************************************************
    localparam logic [1:0] MONO_STEREO = 2'h0;
    localparam logic [1:0] MONO_RIGHT  = 2'h2;
    localparam logic [1:0] BSYNC_TX    = 2'h1;
    localparam logic       FMT_I2S     = 1'h0;
    localparam logic       RATIO_128   = 1'h1;

    // preambles as eight half-cells, msb first, from level 0
    localparam logic [7:0] PRE_B = 8'hE8;
    localparam logic [7:0] PRE_M = 8'hE2;
    localparam logic [7:0] PRE_W = 8'hE4;

    // ****************************************************
    // positions and counts
    // ****************************************************
    localparam int         SY_MCLK   = 0;
    localparam int         SY_BCLK   = 1;
    localparam int         SY_LRCK   = 2;
    localparam int         SY_DATA   = 3;
    localparam int         SY_AUX    = 4;
    localparam int         SY_VAL    = 5;
    localparam int         SY_USR    = 6;
    localparam int         SY_STRAP  = 7;
    localparam logic [1:0] STRAP_WAIT = 2'h3;
    localparam logic [6:0] HC_LAST   = 7'h7F;
    localparam logic [4:0] SLOT_PRE  = 5'h04;
    localparam logic [7:0] FR_LAST   = 8'hBF;
    localparam logic [7:0] CS_BITS   = 8'h30;
    localparam logic [8:0] MCLK_256  = 9'h100;
    localparam logic [8:0] MCLK_128  = 9'h080;

endpackage

// [biphase_source_model.sv]
`timescale 1ns/10ps
module biphase_source_model (
    // ratio chosen by the bench
    input  wire logic ratio_128,
    // source clocks and data
    output logic      mclk,
    output logic      bclk,
    output logic      lrck,
    output logic      sdata,
    output logic      aux_data,
    output logic      vflag,
    output logic      uflag
);
    logic [15:0] lf;
    int          bit_n, frm, k;

    // bit clock period in eight 6 ns steps, phase offset to ref_clk
    initial begin
        {mclk, bclk, lrck, sdata, aux_data, vflag, uflag} = '0;
        lf    = 16'hACE1;
        bit_n = 0;
        frm   = 0;
        #1.3;
        forever begin
            for (k = 0; k < 8; k++) begin
                // 256fs rises and 128fs falls with bit clock fall
                mclk = ratio_128 ? k[1] : !k[0];
                bclk = k >= 4; // 64fs
                if (k == 0) begin
                    // frame clock and data move on the fall
                    lrck     = bit_n >= 32;
                    lf       = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
                    sdata    = lf[0];
                    aux_data = lf[7];
                    // flags once a frame, alike in both slots
                    if (bit_n == 0) begin
                        vflag = frm[0];
                        uflag = frm[1];
                        frm++;
                    end
                    bit_n = (bit_n + 1) % 64;
                end
                #6;
            end
        end
    end
endmodule

// [biphase_audio_modulator_sva.sv]
`timescale 1ns/10ps
module biphase_audio_modulator_sva (
    // clock and reset
    input wire logic        ref_clk,
    input wire logic        reset,
    // register bus
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic [31:0] hwdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    // stream and shared pins
    input wire logic        encoded_stream_out,
    input wire logic        input_passthrough_out,
    input wire logic        clkstate_blocksync_oe
);
    localparam logic [11:0] LIVE = 12'hFA0;
    localparam logic [7:0]  HOLD = 8'h2C;
    logic        wc_q, enc_q;
    logic [12:0] ctl_q;
    logic [11:0] live_q;
    logic [7:0]  hold_q;

    // shadow of the control word
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            wc_q  <= 1'b0;
            ctl_q <= '0;
        end else if (hready) begin
            wc_q <= hsel && htrans[1] && hwrite && haddr == 32'h0;
            if (wc_q)
                ctl_q <= hwdata[12:0];
        end
    end

    // cycles running unmuted, cycles since last output edge
    always_ff @(posedge ref_clk) begin
        enc_q <= encoded_stream_out;
        if (reset || wc_q || !ctl_q[0] || ctl_q[1])
            live_q <= '0;
        else if (live_q != 12'hFFF)
            live_q <= live_q + 12'h1;
        if (reset || enc_q != encoded_stream_out)
            hold_q <= '0;
        else if (hold_q != 8'hFF)
            hold_q <= hold_q + 8'h1;
    end

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (reset);

    sequence s_stopped;
        (!ctl_q[0]) [*3];
    endsequence
    sequence s_aux_src;
        ctl_q[10] [*3];
    endsequence

    a_bus_okay:
        assert property (hreadyout && !hresp)
        else $error("bus answer not okay");
    a_stop_low:
        assert property (s_stopped |-> !encoded_stream_out)
        else $error("stream active while stopped");
    a_mute_low:
        assert property (ctl_q[1] [*3] |-> !encoded_stream_out)
        else $error("stream active while muted");
    a_sync_drive:
        assert property ((ctl_q[9:8] == 2'h1) [*3] |-> clkstate_blocksync_oe)
        else $error("block sync not driven");
    a_sync_off:
        assert property ((ctl_q[9:8] != 2'h1) [*3] |-> !clkstate_blocksync_oe)
        else $error("block sync driven when not chosen");
    a_pass_off:
        assert property ((!ctl_q[10]) [*3] |-> !input_passthrough_out)
        else $error("passthrough active without aux source");
    a_pass_same:
        assert property (s_aux_src |->
            input_passthrough_out == encoded_stream_out)
        else $error("passthrough differs from stream");
    a_cells_move:
        assert property (live_q >= LIVE |-> hold_q < HOLD)
        else $error("stream stuck while running");
endmodule

bind biphase_audio_modulator biphase_audio_modulator_sva u_sva (
    .ref_clk, .reset, .hsel, .haddr, .htrans, .hwrite, .hready, .hwdata,
    .hreadyout, .hresp, .encoded_stream_out, .input_passthrough_out,
    .clkstate_blocksync_oe
);

// [biphase_audio_modulator_test.sv]
`timescale 1ns/10ps
module biphase_audio_modulator_test
    import biphase_pkg::*;
;
    // ********
    // signals
    // ********
    logic        ref_clk, reset, hsel, hwrite, ratio, pick, strap;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [31:0] haddr, hwdata, rng;
    logic        mclk, bclk, lrck, sdata, adata, vflag, uflag;
    wire  [31:0] hrdata;
    wire         hready, hresp, enc, pass, bs_out, bs_oe, probe;
    logic [31:0] mdl [8];
    logic [31:0] cfg [4] = '{32'h1, 32'h9, 32'h11, 32'h19};
    int          n_fail, check_count, n, hc, mis, tg;

    // source, design and probe of the measured line
    biphase_source_model u_src (
        .ratio_128(ratio), .mclk, .bclk, .lrck, .sdata,
        .aux_data(adata), .vflag, .uflag
    );
    biphase_audio_modulator u_dut (
        .ref_clk, .reset, .hsel, .haddr, .htrans, .hwrite, .hsize,
        .hready, .hwdata, .hrdata, .hreadyout(hready), .hresp,
        .tx_master_clk_in(mclk), .tx_bit_clk_in(bclk),
        .tx_frame_clk_in(lrck), .tx_serial_data_in(sdata),
        .aux_serial_audio_in(adata), .aux_in5_validity(vflag),
        .aux_in6_user(uflag), .int_strap_pin(strap),
        .encoded_stream_out(enc), .input_passthrough_out(pass),
        .clkstate_blocksync_out(bs_out), .clkstate_blocksync_oe(bs_oe)
    );
    assign probe = pick ? bs_out : enc;

    // 250 MHz clock
    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = !ref_clk;
    end

    // ********
    // helpers
    // ********
    function automatic logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction

    // writable bits of each register index
    function automatic logic [31:0] wm(input logic [2:0] i);
        case (i)
            3'h0: return 32'h1FFF;
            3'h1: return 32'hFFFFFFFF;
            3'h2: return 32'hFFFF;
            3'h3: return mdl[0][6] ? 32'h3 : 32'h0;
            3'h4: return 32'h3;
            default: return 32'h0;
        endcase
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    task automatic in_rng(input int v, input int lo, input int up);
        chk(32'((v >= lo && v <= up) ? lo : v), 32'(lo));
    endtask

    // one transfer: address phase, then data phase
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] r);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr  <= {24'h0, a};
        do @(posedge ref_clk); while (hready !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= w ? d : 32'h0;
        do @(posedge ref_clk); while (hready !== 1'b1);
        r = hrdata;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        bus(1'b1, a, d, r);
        mdl[a[4:2]] = (mdl[a[4:2]] & ~wm(a[4:2])) | (d & wm(a[4:2]));
        ratio = mdl[0][2];
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] m);
        logic [31:0] r;
        bus(1'b0, a, 32'h0, r);
        chk(r & m, mdl[a[4:2]] & m);
    endtask

    // wait for a high level, then count its length
    task automatic hi_len(input logic s, input int lim, output int len);
        int t;
        pick = s;
        t = 0;
        len = 0;
        while (probe !== 1'b1 && t < lim) begin
            @(posedge ref_clk);
            t++;
        end
        while (probe === 1'b1 && len < lim) begin
            @(posedge ref_clk);
            len++;
        end
    endtask

    // highs, passthrough mismatches and edges of the stream
    task automatic watch(input int cyc, output int h, m, e);
        logic last;
        {h, m, e} = '0;
        // let the last control write reach the output flops
        @(posedge ref_clk);
        last = enc;
        repeat (cyc) begin
            @(posedge ref_clk);
            h += enc;
            m += (pass !== enc);
            e += (enc !== last);
            last = enc;
        end
    endtask

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // watchdog
    initial begin
        #150000;
        n_fail++;
        report_and_stop();
    end

    // ********
    // main sequence
    // ********
    initial begin
        reset = 1'b1;
        {hsel, hwrite, ratio, pick, strap} = '0;
        {htrans, haddr, hwdata} = '0;
        hsize = 3'h2;
        rng = 32'h3C59A1A2;
        mdl = '{default: 32'h0};
        mdl[5] = 32'h2;
        {n_fail, check_count} = '0;
        repeat (10) @(posedge ref_clk);
        reset <= 1'b0;
        repeat (4) @(posedge ref_clk);
        // reset values, random fill, validity write gating
        for (int p = 0; p < 3; p++) begin
            for (int i = 0; i < 8; i++)
                rd(8'(i * 4), i == 5 ? 32'h2 : 32'hFFFFFFFF);
            wr(ADDR_CTRL, p == 1 ? 32'h40 : 32'h0);
            for (int i = 1; i < 8; i++) begin
                rng = xs(rng);
                wr(8'(i * 4), rng);
            end
        end
        // every polarity and format starts with preamble B
        foreach (cfg[i]) begin
            wr(ADDR_CTRL, 32'h0);
            wr(ADDR_CTRL, cfg[i]);
            hi_len(1'b0, 4000, n);
            in_rng(n, 16, 20);
        end
        repeat (800) @(posedge ref_clk);
        mdl[5] = 32'h7;
        rd(ADDR_STATUS, 32'h7);
        // block sync over frame 0, stereo then mono
        wr(ADDR_CTRL, 32'h0);
        wr(ADDR_CTRL, 32'h101);
        hi_len(1'b1, 4000, n);
        in_rng(n, 760, 776);
        wr(ADDR_CTRL, 32'h0);
        wr(ADDR_CTRL, 32'h9A5);
        hi_len(1'b1, 8000, n);
        in_rng(n, 1528, 1544);
        rd(ADDR_STATUS, 32'h7);
        // mute holds the line low, encoder keeps going
        wr(ADDR_CTRL, 32'h0);
        wr(ADDR_CTRL, 32'h1);
        repeat (2000) @(posedge ref_clk);
        wr(ADDR_CTRL, 32'h3);
        watch(1000, hc, mis, tg);
        chk(32'(hc), 32'h0);
        wr(ADDR_CTRL, 32'h1);
        hi_len(1'b0, 60, n);
        in_rng(n, 1, 20);
        // aux source on both outputs
        wr(ADDR_CTRL, 32'h401);
        watch(5000, hc, mis, tg);
        chk(32'(mis), 32'h0);
        in_rng(tg, 200, 840);
        report_and_stop();
    end
endmodule
